// ---- inc/host_port_pkg.sv ----
package host_port_pkg;

	// Frame widths on the serial link.
	localparam int CMD_BITS = 5;
	localparam int RESULT_BITS = 16;
	localparam int REG_ADDR_BITS = 15;
	localparam int REG_DATA_BITS = 8;
	localparam int HDR_BITS = 16;
	localparam int CFG_REGS = 16;
	localparam logic [REG_DATA_BITS-1:0] CFG_RESET_VALUE = 8'h00;

	// Multi-function pin selections.
	typedef enum logic [1:0] {
		MFP_GPIO = 2'h0,
		MFP_ALERT = 2'h1,
		MFP_BUSY = 2'h2,
		MFP_SDO2 = 2'h3
	} mfp_mode_t;

	// Serial port states, one-hot.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_HDR = 4'h2,
		ST_DATA = 4'h4,
		ST_CONV = 4'h8
	} port_state_t;

	// Synchronised host pins travelling together.
	typedef struct packed {
		logic sck;
		logic sdi;
		logic cs_b;
		logic convert_start;
		logic gpio_in;
	} host_pins_t;

	// Block-side conversion handshake.
	typedef struct packed {
		logic alert;
		logic busy;
		logic [RESULT_BITS-1:0] result;
	} conv_status_t;

endpackage : host_port_pkg

// ---- src/adc_serial_host_port.sv ----
`timescale 1ns/1ns
module adc_serial_host_port (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Host pins.
	input wire logic sck,
	input wire logic sdi,
	input wire logic cs_b,
	input wire logic convert_start,
	input wire logic reset_pin_b,
	output logic sdo,
	// Multi-function pin as three signals.
	input wire logic mfp_in,
	output logic mfp_out,
	output logic mfp_oe,
	// Block side.
	input wire logic conv_mode,
	input wire host_port_pkg::mfp_mode_t mfp_mode,
	input wire logic gpio_out_value,
	input wire logic gpio_dir_out,
	input wire host_port_pkg::conv_status_t conv_status,
	output logic conv_start_pulse,
	output logic [host_port_pkg::CMD_BITS-1:0] cmd_word,
	output logic cmd_valid,
	output logic gpio_in_value
);
	import host_port_pkg::*;

	// Two-stage synchronisers; logic reads the second stage and a one-cycle delayed copy of it.
	host_pins_t meta_ff, sync_ff, prev_ff;
	logic rst_meta_ff, rst_sync_ff;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '{sck: 1'h0, sdi: 1'h0, cs_b: 1'h1, convert_start: 1'h0, gpio_in: 1'h0};
			sync_ff <= '{sck: 1'h0, sdi: 1'h0, cs_b: 1'h1, convert_start: 1'h0, gpio_in: 1'h0};
			prev_ff <= '{sck: 1'h0, sdi: 1'h0, cs_b: 1'h1, convert_start: 1'h0, gpio_in: 1'h0};
			// Idle level of the reset pin, so no stray port reset follows the system reset.
			rst_meta_ff <= 1'h1;
			rst_sync_ff <= 1'h1;
		end else begin
			meta_ff <= '{sck: sck, sdi: sdi, cs_b: cs_b, convert_start: convert_start,
				gpio_in: mfp_in};
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
			rst_meta_ff <= reset_pin_b;
			rst_sync_ff <= rst_meta_ff;
		end
	end

	// Edge and level events seen on the system clock.
	logic sck_rise, sck_fall, cs_fall, cs_active, cnv_rise, pin_reset;
	always_comb begin
		sck_rise = sync_ff.sck & ~prev_ff.sck;
		sck_fall = ~sync_ff.sck & prev_ff.sck;
		cs_active = ~sync_ff.cs_b;
		cs_fall = ~sync_ff.cs_b & prev_ff.cs_b;
		cnv_rise = sync_ff.convert_start & ~prev_ff.convert_start;
		pin_reset = ~rst_sync_ff;
	end

	// Port state and shift registers.
	port_state_t state_ff, nxt_state;
	logic [HDR_BITS-1:0] shin_ff, nxt_shin;
	logic [RESULT_BITS-1:0] shout_ff, nxt_shout;
	logic [4:0] bits_ff, nxt_bits;
	logic rd_ff, nxt_rd;
	logic [REG_ADDR_BITS-1:0] addr_ff, nxt_addr;
	logic sdo_ff, nxt_sdo, sdo2_ff, nxt_sdo2;
	logic [CMD_BITS-1:0] cmd_ff, nxt_cmd;
	logic cmd_valid_ff, nxt_cmd_valid, start_ff, nxt_start;
	logic [REG_DATA_BITS-1:0] cfg_ff [CFG_REGS];
	logic [REG_DATA_BITS-1:0] nxt_cfg [CFG_REGS];
	logic [3:0] idx;

	// Frame engine: the host clock drives all shifting in both modes.
	always_comb begin
		nxt_state = state_ff;
		nxt_shin = shin_ff;
		nxt_shout = shout_ff;
		nxt_bits = bits_ff;
		nxt_rd = rd_ff;
		nxt_addr = addr_ff;
		nxt_sdo = sdo_ff;
		nxt_sdo2 = sdo2_ff;
		nxt_cmd = cmd_ff;
		nxt_cmd_valid = 1'h0;
		nxt_start = 1'h0;
		nxt_cfg = cfg_ff;
		idx = addr_ff[3:0];
		if (pin_reset) begin
			nxt_state = ST_IDLE;
			nxt_bits = 5'h00;
			nxt_sdo = 1'h0;
			nxt_sdo2 = 1'h0;
			for (int i = 0; i < CFG_REGS; i++) begin
				nxt_cfg[i] = CFG_RESET_VALUE;
			end
		end else begin
			// Conversion start is only honoured in conversion mode.
			if (conv_mode && cnv_rise) begin
				nxt_start = 1'h1;
			end
			case (state_ff)
				ST_IDLE: begin
					if (cs_fall || (conv_mode && cs_active)) begin
						nxt_bits = 5'h00;
						nxt_shin = '0;
						if (conv_mode) begin
							nxt_state = ST_CONV;
							nxt_shout = conv_status.result;
							nxt_sdo = conv_status.result[RESULT_BITS-1];
							nxt_sdo2 = conv_status.result[RESULT_BITS/2-1];
						end else begin
							nxt_state = ST_HDR;
						end
					end
				end
				ST_HDR: begin
					if (!cs_active) begin
						nxt_state = ST_IDLE;
					end else if (sck_rise) begin
						nxt_shin = {shin_ff[HDR_BITS-2:0], sync_ff.sdi};
						nxt_bits = bits_ff + 5'h01;
						if (bits_ff == 5'(HDR_BITS - 1)) begin
							nxt_rd = shin_ff[HDR_BITS-2];
							nxt_addr = {shin_ff[REG_ADDR_BITS-2:0], sync_ff.sdi};
							nxt_bits = 5'h00;
							nxt_state = ST_DATA;
							idx = nxt_addr[3:0];
							nxt_shout = {cfg_ff[idx], 8'h00};
						end
					end
				end
				ST_DATA: begin
					if (!cs_active) begin
						nxt_state = ST_IDLE;
						nxt_sdo = 1'h0;
					end else if (sck_fall && rd_ff) begin
						nxt_sdo = shout_ff[RESULT_BITS-1];
						nxt_shout = {shout_ff[RESULT_BITS-2:0], 1'h0};
					end else if (sck_rise) begin
						nxt_shin = {shin_ff[HDR_BITS-2:0], sync_ff.sdi};
						nxt_bits = bits_ff + 5'h01;
						if (bits_ff == 5'(REG_DATA_BITS - 1)) begin
							// Writes land once the byte is whole; partial bytes are dropped.
							if (!rd_ff) begin
								nxt_cfg[idx] = {shin_ff[REG_DATA_BITS-2:0], sync_ff.sdi};
							end
							nxt_bits = 5'h00;
							nxt_addr = addr_ff + 15'h0001;
							nxt_shout = {cfg_ff[4'(addr_ff[3:0] + 4'h1)], 8'h00};
						end
					end
				end
				ST_CONV: begin
					if (!cs_active || !conv_mode) begin
						nxt_state = ST_IDLE;
					end else if (sck_fall) begin
						nxt_shout = {shout_ff[RESULT_BITS-2:0], 1'h0};
						nxt_sdo = shout_ff[RESULT_BITS-2];
						nxt_sdo2 = shout_ff[RESULT_BITS/2-2];
					end else if (sck_rise) begin
						nxt_shin = {shin_ff[HDR_BITS-2:0], sync_ff.sdi};
						// The count stops at its top so a long frame never wraps into a second command.
						if (bits_ff != 5'h1F) begin
							nxt_bits = bits_ff + 5'h01;
						end
						if (bits_ff == 5'(CMD_BITS - 1)) begin
							nxt_cmd = {shin_ff[CMD_BITS-2:0], sync_ff.sdi};
							nxt_cmd_valid = 1'h1;
						end
					end
				end
				default: nxt_state = ST_IDLE;
			endcase
		end
	end

	// Multi-function pin routing; the enable follows the selected role.
	logic nxt_mfp_out, nxt_mfp_oe;
	mfp_mode_t mode_q;
	always_comb begin
		mode_q = mfp_mode;
		case (mode_q)
			MFP_GPIO: begin
				nxt_mfp_out = gpio_out_value;
				nxt_mfp_oe = gpio_dir_out;
			end
			MFP_ALERT: begin
				nxt_mfp_out = conv_status.alert;
				nxt_mfp_oe = 1'h1;
			end
			MFP_BUSY: begin
				nxt_mfp_out = conv_status.busy;
				nxt_mfp_oe = 1'h1;
			end
			MFP_SDO2: begin
				nxt_mfp_out = nxt_sdo2;
				nxt_mfp_oe = 1'h1;
			end
			default: begin
				nxt_mfp_out = 1'h0;
				nxt_mfp_oe = 1'h0;
			end
		endcase
	end

	// State registers; the pin reset also acts through the next-state logic.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= ST_IDLE;
			shin_ff <= '0;
			shout_ff <= '0;
			bits_ff <= 5'h00;
			rd_ff <= 1'h0;
			addr_ff <= '0;
			sdo_ff <= 1'h0;
			sdo2_ff <= 1'h0;
			cmd_ff <= '0;
			cmd_valid_ff <= 1'h0;
			start_ff <= 1'h0;
			mfp_out <= 1'h0;
			mfp_oe <= 1'h0;
			gpio_in_value <= 1'h0;
			for (int i = 0; i < CFG_REGS; i++) begin
				cfg_ff[i] <= CFG_RESET_VALUE;
			end
		end else begin
			state_ff <= nxt_state;
			shin_ff <= nxt_shin;
			shout_ff <= nxt_shout;
			bits_ff <= nxt_bits;
			rd_ff <= nxt_rd;
			addr_ff <= nxt_addr;
			sdo_ff <= nxt_sdo;
			sdo2_ff <= nxt_sdo2;
			cmd_ff <= nxt_cmd;
			cmd_valid_ff <= nxt_cmd_valid;
			start_ff <= nxt_start;
			mfp_out <= nxt_mfp_out;
			mfp_oe <= nxt_mfp_oe;
			gpio_in_value <= sync_ff.gpio_in;
			cfg_ff <= nxt_cfg;
		end
	end

	// Outputs are direct flop copies.
	assign sdo = sdo_ff;
	assign cmd_word = cmd_ff;
	assign cmd_valid = cmd_valid_ff;
	assign conv_start_pulse = start_ff;

endmodule : adc_serial_host_port

// ---- verification/adc_serial_host_port_chk.sv ----
`timescale 1ns/1ns
module adc_serial_host_port_chk (
	// Clock and reset.
	input wire logic mclk,
	input wire logic rst_b,
	// Pins.
	input wire logic sck,
	input wire logic cs_b,
	input wire logic convert_start,
	input wire logic reset_pin_b,
	input wire logic sdo,
	input wire logic mfp_out,
	input wire logic mfp_oe,
	// Block side.
	input wire logic conv_mode,
	input wire host_port_pkg::mfp_mode_t mfp_mode,
	input wire logic gpio_out_value,
	input wire logic gpio_dir_out,
	input wire host_port_pkg::conv_status_t conv_status,
	input wire logic conv_start_pulse,
	input wire logic cmd_valid
);
	import host_port_pkg::*;
	// Checks sleep in reset, since outputs are forced low there.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Pin to pulse: two synchroniser stages and the pulse register.
	chk_start_lag: assert property (
		$rose(convert_start) && conv_mode |-> ##3 conv_start_pulse) else $error("start late");
	chk_start_mode: assert property (
		!conv_mode [*5] |-> !conv_start_pulse) else $error("start in reg mode");
	chk_cmd_mode: assert property (
		!conv_mode [*8] |-> !cmd_valid) else $error("cmd in reg mode");
	chk_sdo_edge: assert property (
		$changed(sdo) |-> !sck) else $error("sdo moved with clock high");
	chk_gpio_drive: assert property (
		mfp_mode == MFP_GPIO && $stable(mfp_mode) && $stable(gpio_dir_out) && $stable(gpio_out_value)
		|-> mfp_oe == gpio_dir_out && (!gpio_dir_out || mfp_out == gpio_out_value))
		else $error("gpio drive wrong");
	chk_busy_pin: assert property (
		mfp_mode == MFP_BUSY && $stable(mfp_mode) && $stable(conv_status.busy)
		|-> mfp_oe && mfp_out == conv_status.busy) else $error("busy pin wrong");
	chk_alert_pin: assert property (
		mfp_mode == MFP_ALERT && $stable(mfp_mode) && $stable(conv_status.alert)
		|-> mfp_oe && mfp_out == conv_status.alert) else $error("alert pin wrong");
	chk_reset_pin: assert property (
		!reset_pin_b [*4] |-> !sdo && !cmd_valid && !conv_start_pulse) else $error("port not inert");
	// Main scenarios reached.
	cover property (cmd_valid);
	cover property (conv_start_pulse);
	cover property (!cs_b && mfp_mode == MFP_SDO2 && sdo);
endmodule : adc_serial_host_port_chk

bind adc_serial_host_port adc_serial_host_port_chk u_chk (.mclk, .rst_b, .sck, .cs_b,
	.convert_start, .reset_pin_b, .sdo, .mfp_out, .mfp_oe, .conv_mode, .mfp_mode,
	.gpio_out_value, .gpio_dir_out, .conv_status, .conv_start_pulse, .cmd_valid);

// ---- verification/adc_serial_host_port_tb_top.sv ----
`timescale 1ns/1ns
module adc_serial_host_port_tb_top;
	import host_port_pkg::*;
	// Stimulus and observed signals.
	logic mclk = 1'h0, rst_b = 1'h0, sck, sdi, cs_b, sdo, mfp_in, mfp_out, mfp_oe;
	logic convert_start = 1'h0, reset_pin_b = 1'h1, pin_lvl = 1'h0, conv_mode = 1'h0;
	logic gpio_out_value = 1'h0, gpio_dir_out = 1'h0, conv_start_pulse, cmd_valid, gpio_in_value;
	mfp_mode_t mfp_mode = MFP_GPIO;
	conv_status_t conv_status = '0;
	logic [CMD_BITS-1:0] cmd_word;
	logic [7:0] q, q2;
	int miscompares = 0, comparisons = 0, pulses = 0, cmds = 0;
	always #10 mclk = ~mclk;
	// The pin shows the port's drive when enabled, else the board level.
	assign mfp_in = mfp_oe ? mfp_out : pin_lvl;
	// One-cycle pulses are counted at the falling edge, clear of the edge that launches them.
	always @(negedge mclk) begin
		if (conv_start_pulse === 1'h1) pulses++;
		if (cmd_valid === 1'h1) cmds++;
	end
	adc_serial_host_port u_adc_serial_host_port (.mclk, .rst_b, .sck, .sdi, .cs_b,
		.convert_start, .reset_pin_b, .sdo, .mfp_in, .mfp_out, .mfp_oe, .conv_mode, .mfp_mode,
		.gpio_out_value, .gpio_dir_out, .conv_status, .conv_start_pulse, .cmd_word, .cmd_valid,
		.gpio_in_value);
	spi_host_model host (.mclk, .sck, .sdi, .cs_b, .sdo, .mfp_out);
	task automatic check(input string what, input logic [7:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	// Auto-incremented write, read back, then the reset pin clears it.
	task automatic t_regs;
		host.xfer(32, 32'h0003A53C, q, q2);
		host.xfer(24, 32'h00800400, q, q2);
		check("reg4", q, 8'h3C);
		host.xfer(24, 32'h00800300, q, q2);
		check("reg3", q, 8'hA5);
		check("reg cmds", 8'(cmds), 8'h00);
		reset_pin_b = 1'h0;
		repeat (8) @(negedge mclk);
		reset_pin_b = 1'h1;
		repeat (4) @(negedge mclk);
		host.xfer(24, 32'h00800300, q, q2);
		check("reg3 reset", q, CFG_RESET_VALUE);
		$display("regs done");
	endtask : t_regs
	// Dual-lane result readout with a command, then convert start in both modes.
	task automatic t_conv;
		conv_mode = 1'h1;
		mfp_mode = MFP_SDO2;
		conv_status.result = 16'hB38D;
		host.xfer(8, 32'h000000A8, q, q2);
		check("sdo lane", q, 8'hB3);
		check("mfp lane", q2, 8'h8D);
		check("cmd", {3'h0, cmd_word}, 8'h15);
		check("cmd count", 8'(cmds), 8'h01);
		for (int m = 1; m >= 0; m--) begin
			conv_mode = m[0];
			pulses = 0;
			repeat (4) @(negedge mclk);
			convert_start = 1'h1;
			repeat (8) @(negedge mclk);
			convert_start = 1'h0;
			repeat (4) @(negedge mclk);
			check("starts", 8'(pulses), {7'h0, m[0]});
		end
		$display("conv done");
	endtask : t_conv
	// GPIO, alert and busy functions drive high, low and high; then the pin as input.
	task automatic t_mfp;
		gpio_dir_out = 1'h1;
		gpio_out_value = 1'h1;
		conv_status.busy = 1'h1;
		for (int i = 0; i < 3; i++) begin
			mfp_mode = mfp_mode_t'(i);
			repeat (3) @(negedge mclk);
			check("mfp", {6'h0, mfp_oe, mfp_out}, {7'h1, i != 1});
		end
		mfp_mode = MFP_GPIO;
		gpio_dir_out = 1'h0;
		// Both board levels, so a stuck input cannot pass.
		for (int v = 0; v < 2; v++) begin
			pin_lvl = v[0];
			repeat (6) @(negedge mclk);
			check("gpio oe", {7'h0, mfp_oe}, 8'h00);
			check("gpio in", {7'h0, gpio_in_value}, {7'h0, v[0]});
		end
		$display("mfp done");
	endtask : t_mfp
	initial begin
		repeat (2) @(negedge mclk);
		rst_b = 1'h1;
		repeat (3) @(negedge mclk);
		check("idle", {4'h0, sdo, mfp_oe, cmd_valid, conv_start_pulse}, 8'h00);
		t_regs();
		t_conv();
		t_mfp();
		end_of_test();
	end
	// A hang is cut short and counted.
	initial begin
		#1000000;
		miscompares++;
		end_of_test();
	end
endmodule : adc_serial_host_port_tb_top

// ---- verification/spi_host_model.sv ----
`timescale 1ns/1ns
module spi_host_model (
	// Clock.
	input wire logic mclk,
	// Host pins.
	output logic sck,
	output logic sdi,
	output logic cs_b,
	// Device outputs.
	input wire logic sdo,
	input wire logic mfp_out
);
	// Clock stands low and the part is deselected outside frames.
	initial begin
		sck = 1'h0;
		sdi = 1'h0;
		cs_b = 1'h1;
	end
	// Framed transfer, MSB first; each half period is four system clocks for the synchroniser.
	task automatic xfer(input int n, input logic [31:0] mosi, output logic [7:0] q, q2);
		@(negedge mclk) cs_b = 1'h0;
		repeat (4) @(negedge mclk);
		for (int i = n - 1; i >= 0; i--) begin
			sdi = mosi[i];
			repeat (4) @(negedge mclk);
			q = {q[6:0], sdo}; // and
			q2 = {q2[6:0], mfp_out};
			sck = 1'h1;
			repeat (4) @(negedge mclk);
			sck = 1'h0;
		end
		repeat (4) @(negedge mclk);
		cs_b = 1'h1;
		sdi = ~sdi;
		repeat (8) @(negedge mclk);
	endtask : xfer
endmodule : spi_host_model
